// ### rtl/abi_pkg.sv
// Constants shared by both ends of the converter bus interface.
// Assumes a single 40 MHz system clock on both ends.
package abi_pkg;

  // ---------------------------------------------------------------
  // Data and address
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam logic [7:0] BUS_IDLE = 8'hFF; // Level of an undriven, pulled-up bus
  localparam logic [7:0] MSB_MASK = 8'h80; // First trial bit of the approximation
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int START_ADDR_HI = 1; // Bit eleven level for the start address
  localparam int START_ADDR_LO = 0; // Bit ten level for the start address

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_HZ = 40_000_000;
  localparam int CONV_CLK_HZ = 1_000_000;
  localparam int CONV_HALF_CYCLES = CLOCK_HZ / (2 * CONV_CLK_HZ);
  localparam int CONV_CYCLES = 40; // Converter clocks per conversion
  localparam int BIT_CYCLES = CONV_CYCLES / DATA_W; // Converter clocks per result bit
  localparam int STRETCH_FALLS = 2; // Converter falling edges the start gate spans
  localparam int READY_MARGIN = 2; // Extra converter clocks before a read
  localparam int READY_FALLS = CONV_CYCLES + READY_MARGIN;
  localparam int READ_SETTLE = 4; // System clocks from enable to capture

  // ---------------------------------------------------------------
  // Converter states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ABI_IDLE = 2'b01,
    ABI_CONV = 2'b10
  } abi_state_type;

endpackage : abi_pkg

// ### rtl/abi_link_if.sv
// Wires between the converter and its bus-side control logic.
// Assumes both ends sit on the same system clock; the bus is pulled up.
`timescale 1ns/1ps
interface abi_link_if;
  logic conv_clk;
  logic start_convert_gate;
  logic output_enable;
  logic conv_done;
  logic [abi_pkg::DATA_W-1:0] conv_data;
  logic conv_data_oe;
  logic [abi_pkg::DATA_W-1:0] bus_data;

  // Resolved level of the three-state data lines
  assign bus_data = conv_data_oe ? conv_data : abi_pkg::BUS_IDLE;

  modport dev (
    input conv_clk,
    input start_convert_gate,
    input output_enable,
    output conv_done,
    output conv_data,
    output conv_data_oe
  );

  modport host (
    output conv_clk,
    output start_convert_gate,
    output output_enable,
    input conv_done,
    input bus_data
  );
endinterface : abi_link_if

// ### rtl/abi_converter.sv
// Successive-approximation converter end of the link.
// Assumes the link pins and the analog level are asynchronous to clock_i.
`timescale 1ns/1ps
module abi_converter (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Link to the bus side
  abi_link_if.dev link,
  // Sampled analog level
  input wire logic [abi_pkg::DATA_W-1:0] analog_level_i,
  // Status
  output logic busy_o,
  output logic [abi_pkg::DATA_W-1:0] result_o
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [abi_pkg::DATA_W-1:0] ana_meta;
  logic [abi_pkg::DATA_W-1:0] ana_sync;
  logic clk_prev;
  logic clk_fall;

  // Two stages on every pin before any logic looks at it
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      ana_meta <= abi_pkg::ZERO_BYTE;
      ana_sync <= abi_pkg::ZERO_BYTE;
      clk_prev <= 1'b0;
    end else begin
      pin_meta <= {link.output_enable, link.start_convert_gate, link.conv_clk};
      pin_sync <= pin_meta;
      ana_meta <= analog_level_i;
      ana_sync <= ana_meta;
      clk_prev <= pin_sync[0];
    end
  end

  assign clk_fall = clk_prev & ~pin_sync[0];

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  abi_pkg::abi_state_type state;
  logic [5:0] cycle_cnt;
  logic [2:0] sub_cnt;
  logic [abi_pkg::DATA_W-1:0] trial_mask;
  logic [abi_pkg::DATA_W-1:0] sar;
  logic [abi_pkg::DATA_W-1:0] next_sar;
  logic [abi_pkg::DATA_W-1:0] result;
  logic done;
  logic busy;
  logic data_oe;
  logic bit_slot_end;
  logic last_cycle;

  assign bit_slot_end = (sub_cnt == 3'(abi_pkg::BIT_CYCLES - 1));
  assign last_cycle = (cycle_cnt == 6'(abi_pkg::CONV_CYCLES - 1));

  // Trial bit kept when the live input is at or above it
  always_comb begin
    next_sar = sar;
    if (bit_slot_end && (ana_sync >= (sar | trial_mask))) begin
      next_sar = sar | trial_mask;
    end
  end

  // State, counters and approximation register
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state <= abi_pkg::ABI_IDLE;
      cycle_cnt <= 6'h00;
      sub_cnt <= 3'h0;
      trial_mask <= abi_pkg::MSB_MASK;
      sar <= abi_pkg::ZERO_BYTE;
    end else if (clk_fall) begin
      case (state)
        abi_pkg::ABI_IDLE: begin
          // A start arriving mid-conversion is simply not looked at
          if (pin_sync[1]) begin
            state <= abi_pkg::ABI_CONV;
            cycle_cnt <= 6'h00;
            sub_cnt <= 3'h0;
            trial_mask <= abi_pkg::MSB_MASK;
            sar <= abi_pkg::ZERO_BYTE;
          end
        end
        abi_pkg::ABI_CONV: begin
          sar <= next_sar;
          cycle_cnt <= cycle_cnt + 6'h01;
          if (bit_slot_end) begin
            sub_cnt <= 3'h0;
            trial_mask <= trial_mask >> 1;
          end else begin
            sub_cnt <= sub_cnt + 3'h1;
          end
          if (last_cycle) begin
            state <= abi_pkg::ABI_IDLE;
          end
        end
        default: begin
          state <= abi_pkg::ABI_IDLE;
        end
      endcase
    end
  end

  // Done flag, busy copy and result latch move together on the last edge;
  // busy has its own flop so the status pin comes straight from a register
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      done <= 1'b1;
      busy <= 1'b0;
      result <= abi_pkg::ZERO_BYTE;
    end else if (clk_fall) begin
      if (state == abi_pkg::ABI_IDLE && pin_sync[1]) begin
        done <= 1'b0;
        busy <= 1'b1;
      end else if (state == abi_pkg::ABI_CONV && last_cycle) begin
        done <= 1'b1;
        busy <= 1'b0;
        result <= next_sar;
      end
    end
  end

  // Drivers enabled only while the enable pin is high
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= pin_sync[2];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.conv_done = done;
  assign link.conv_data = result;
  assign link.conv_data_oe = data_oe;
  assign busy_o = busy;
  assign result_o = result;

endmodule : abi_converter

// ### rtl/abi_bus_side.sv
// Processor-side decode, start stretcher and output-enable control.
// Assumes processor strobes and address bits arrive asynchronously
// and that the converter end joins through abi_link_if.
//
// Operation
// - Conversion starts on clock fall, lasts 40
// - Done goes low and input taken
// - Result found bit by bit, input watched
// - Finished result loads into output latch
// - Done rises together with latching result
// - Latch holds old result until next ends
// - Data lines drive only while enabled
// - Start pulse spans at least one clock
// - Start follows write strobe, stretched if slow
// - Start decodes bit eleven high, ten low
// - Processor holds address steady through cycle
// - Enable set from second address at strobe
// - Enable held until bus request drops
// - Data gated by address-strobe enable, not read
// - No read before 40 converter clocks
// - Enable set: bit ten high, eleven low
`timescale 1ns/1ps
module abi_bus_side #(
  parameter int HALF_CYCLES = abi_pkg::CONV_HALF_CYCLES,
  parameter int READY_FALLS = abi_pkg::READY_FALLS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Processor pins
  input wire logic addr_bit_ten_i,
  input wire logic addr_bit_eleven_i,
  input wire logic address_strobe_n_i,
  input wire logic write_data_strobe_n_i,
  input wire logic bus_request_i,
  // Link to the converter
  abi_link_if.host link,
  // Status and data toward the processor side
  output logic [abi_pkg::DATA_W-1:0] read_data_o,
  output logic read_capture_o,
  output logic result_ready_o,
  output logic conv_done_o,
  output logic start_active_o
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic ads_prev;
  logic addr_ten;
  logic addr_eleven;
  logic ads_n;
  logic wds_n;
  logic bus_req;
  logic ads_fall;

  // Every processor pin passes two stages before use
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pin_meta <= 5'h07;
      pin_sync <= 5'h07;
      ads_prev <= 1'b1;
    end else begin
      pin_meta <= {addr_bit_ten_i, addr_bit_eleven_i, bus_request_i,
                   write_data_strobe_n_i, address_strobe_n_i};
      pin_sync <= pin_meta;
      ads_prev <= pin_sync[0];
    end
  end

  // Address is taken as a level; the processor keeps it steady
  assign ads_n = pin_sync[0];
  assign wds_n = pin_sync[1];
  assign bus_req = pin_sync[2];
  assign addr_eleven = pin_sync[3];
  assign addr_ten = pin_sync[4];
  assign ads_fall = ads_prev & ~ads_n;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic start_hit;
  logic select_hit;

  // Only the two high bits matter, so every alias also decodes
  assign start_hit = (addr_eleven == 1'(abi_pkg::START_ADDR_HI)) &&
                     (addr_ten == 1'(abi_pkg::START_ADDR_LO));
  assign select_hit = (addr_ten == 1'(abi_pkg::START_ADDR_HI)) &&
                      (addr_eleven == 1'(abi_pkg::START_ADDR_LO));

  // ---------------------------------------------------------------
  // Converter clock divider
  // ---------------------------------------------------------------
  localparam int HALF_W = $clog2(HALF_CYCLES + 1);
  logic [HALF_W-1:0] half_cnt;
  logic conv_clk;
  logic conv_fall;

  assign conv_fall = conv_clk && (half_cnt == HALF_W'(HALF_CYCLES - 1));

  // Free-running clock the converter counts its cycles on
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      half_cnt <= '0;
      conv_clk <= 1'b0;
    end else if (half_cnt == HALF_W'(HALF_CYCLES - 1)) begin
      half_cnt <= '0;
      conv_clk <= ~conv_clk;
    end else begin
      half_cnt <= half_cnt + HALF_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Start gate with stretcher
  // ---------------------------------------------------------------
  logic start_gate;
  logic [1:0] stretch_falls;
  logic write_start;

  assign write_start = start_hit && !wds_n;

  // A short write strobe could fall between converter edges, so the
  // gate is held until two converter falls have passed
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      start_gate <= 1'b0;
      stretch_falls <= 2'h0;
    end else if (write_start && !start_gate) begin
      start_gate <= 1'b1;
      stretch_falls <= 2'h0;
    end else if (start_gate) begin
      if (conv_fall && stretch_falls != 2'(abi_pkg::STRETCH_FALLS)) begin
        stretch_falls <= stretch_falls + 2'h1;
      end
      if (!write_start && stretch_falls == 2'(abi_pkg::STRETCH_FALLS)) begin
        start_gate <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result ready timer
  // ---------------------------------------------------------------
  localparam int READY_W = $clog2(READY_FALLS + 1);
  logic [READY_W-1:0] ready_cnt;
  logic ready;

  // Counts converter falls from the start; saturates at the limit
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ready_cnt <= '0;
      ready <= 1'b0;
    end else if (write_start && !start_gate) begin
      ready_cnt <= '0;
      ready <= 1'b0;
    end else if (conv_fall && !ready) begin
      ready_cnt <= ready_cnt + READY_W'(1);
      if (ready_cnt == READY_W'(READY_FALLS - 1)) begin
        ready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output-enable gate
  // ---------------------------------------------------------------
  logic out_enable;

  // Set at address strobe wins over a release in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      out_enable <= 1'b0;
    end else if (ads_fall && select_hit) begin
      out_enable <= 1'b1;
    end else if (!bus_req) begin
      out_enable <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read capture
  // ---------------------------------------------------------------
  logic [2:0] settle_cnt;
  logic [abi_pkg::DATA_W-1:0] read_data;
  logic capture;

  // Enable time, not read strobe, paces the transfer: the converter
  // needs a few cycles to turn its drivers on after the enable
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      settle_cnt <= 3'h0;
      read_data <= abi_pkg::ZERO_BYTE;
      capture <= 1'b0;
    end else begin
      capture <= 1'b0;
      if (!out_enable) begin
        settle_cnt <= 3'h0;
      end else if (settle_cnt != 3'(abi_pkg::READ_SETTLE)) begin
        settle_cnt <= settle_cnt + 3'h1;
        if (settle_cnt == 3'(abi_pkg::READ_SETTLE - 1)) begin
          read_data <= link.bus_data;
          capture <= 1'b1;
        end
      end
    end
  end

  // Converter done level, same clock domain
  logic done_q;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      done_q <= 1'b1;
    end else begin
      done_q <= link.conv_done;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.conv_clk = conv_clk;
  assign link.start_convert_gate = start_gate;
  assign link.output_enable = out_enable;
  assign read_data_o = read_data;
  assign read_capture_o = capture;
  assign result_ready_o = ready;
  assign conv_done_o = done_q;
  assign start_active_o = start_gate;

endmodule : abi_bus_side

// ### verification/abi_link_sva.sv
// Checker on the wires between the converter and its bus side.
// Assumes one system clock, a sync active-low reset and the bench half period.
`timescale 1ns/1ps
module abi_link_sva #(
  parameter int HALF_CYCLES = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Link wires
  input wire logic conv_clk,
  input wire logic start_convert_gate,
  input wire logic output_enable,
  input wire logic conv_done,
  input wire logic [abi_pkg::DATA_W-1:0] conv_data,
  input wire logic conv_data_oe
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  localparam int CONV_LEN = 80 * HALF_CYCLES; // Forty converter clocks
  localparam int START_MAX = 2 * HALF_CYCLES + 8; // One fall plus sync slack
  int low_cnt;
  int half_cnt;
  logic clk_q;
  logic clk_seen;

  // Cycles spent with done low
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || conv_done) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  // Cycles since the converter clock moved; first move is untimed
  always_ff @(posedge clock_i) begin
    clk_q <= conv_clk;
    if (!rst_b_i) begin
      half_cnt <= 0;
      clk_seen <= 1'b0;
    end else if (conv_clk != clk_q) begin
      half_cnt <= 0;
      clk_seen <= 1'b1;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  a_start_min_width: assert property ($rose(start_convert_gate) |-> start_convert_gate[*4])
    else $error("start gate shorter than a converter clock");
  a_start_begins_conv: assert property (
    $rose(start_convert_gate) && conv_done |-> ##[1:START_MAX] !conv_done)
    else $error("start did not begin a conversion");
  a_forty_clocks: assert property ($rose(conv_done) |-> low_cnt == CONV_LEN)
    else $error("conversion length wrong");
  a_latch_with_done: assert property ($changed(conv_data) |-> $rose(conv_done))
    else $error("result changed without done rising");
  a_latch_holds_busy: assert property (!conv_done |-> $stable(conv_data))
    else $error("result moved during conversion");
  a_drive_needs_enable: assert property (conv_data_oe |-> $past(output_enable, 3))
    else $error("data driven without enable");
  a_drive_starts: assert property ($rose(output_enable) |-> ##3 conv_data_oe)
    else $error("data not driven after enable");
  a_drive_stops: assert property ($fell(output_enable) |-> ##3 !conv_data_oe)
    else $error("data still driven after enable dropped");
  a_clk_half_period: assert property (
    conv_clk != clk_q && clk_seen |-> half_cnt == HALF_CYCLES - 1)
    else $error("converter clock half period wrong");
endmodule : abi_link_sva

// ### verification/adc_bus_interface_tb.sv
// Bench for both ends of the converter link joined through abi_link_if.
// Assumes a 2-cycle converter half period; pins change on falling edges.
`timescale 1ns/1ps
module adc_bus_interface_tb;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic addr_bit_ten = 1'b0;
  logic addr_bit_eleven = 1'b0;
  logic address_strobe_n = 1'b1;
  logic write_data_strobe_n = 1'b1;
  logic bus_request = 1'b0;
  logic [7:0] analog_level = 8'h00;
  logic [7:0] read_data;
  logic read_capture;
  logic result_ready;
  logic done_seen;
  logic start_active;
  logic busy;
  logic [7:0] result;
  logic [7:0] levels [5] = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'hA5};
  int err_total = 0;
  int cmp_count = 0;

  // 40 MHz system clock
  always #12.5 clock_i = ~clock_i;

  abi_link_if link ();
  abi_converter u_abi_converter (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(link.dev),
    .analog_level_i(analog_level), .busy_o(busy), .result_o(result));
  abi_bus_side #(.HALF_CYCLES(2), .READY_FALLS(42)) u_abi_bus_side (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .addr_bit_ten_i(addr_bit_ten),
    .addr_bit_eleven_i(addr_bit_eleven), .address_strobe_n_i(address_strobe_n),
    .write_data_strobe_n_i(write_data_strobe_n), .bus_request_i(bus_request),
    .link(link.host), .read_data_o(read_data), .read_capture_o(read_capture),
    .result_ready_o(result_ready), .conv_done_o(done_seen), .start_active_o(start_active));
  abi_link_sva #(.HALF_CYCLES(2)) u_abi_link_sva (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .conv_clk(link.conv_clk), .start_convert_gate(link.start_convert_gate),
    .output_enable(link.output_enable), .conv_done(link.conv_done),
    .conv_data(link.conv_data), .conv_data_oe(link.conv_data_oe));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // Bounded wait on a status level; a miss shows as a mismatch
  task automatic wait_for(input string name, ref logic sig, input logic lvl, input int lim);
    int n;
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(negedge clock_i);
      n++;
    end
    check(name, 8'(sig), 8'(lvl));
  endtask : wait_for

  // Address first, then a write strobe long enough for the sync chain
  task automatic cpu_write(input logic ten, input logic eleven, input logic exp_start);
    @(negedge clock_i);
    addr_bit_ten = ten;
    addr_bit_eleven = eleven;
    @(negedge clock_i);
    write_data_strobe_n = 1'b0;
    repeat (4) @(negedge clock_i);
    check("start gate", 8'(start_active), 8'(exp_start));
    write_data_strobe_n = 1'b1;
    repeat (2) @(negedge clock_i);
  endtask : cpu_write

  // Address strobe with bus request held, then request released
  task automatic cpu_read(input logic ten, input logic eleven, input logic sel,
                          input logic [7:0] exp);
    int caps;
    caps = 0;
    @(negedge clock_i);
    addr_bit_ten = ten;
    addr_bit_eleven = eleven;
    bus_request = 1'b1;
    @(negedge clock_i);
    address_strobe_n = 1'b0;
    repeat (2) @(negedge clock_i);
    address_strobe_n = 1'b1;
    repeat (16) begin
      @(negedge clock_i);
      if (read_capture === 1'b1) caps++;
    end
    check("capture count", 8'(caps), 8'(sel));
    check("enable held", 8'(link.output_enable), 8'(sel));
    if (sel) check("read data", read_data, exp);
    bus_request = 1'b0;
    repeat (10) @(negedge clock_i);
    check("enable cleared", 8'(link.output_enable), 8'h00);
    check("bus released", link.bus_data, 8'hFF);
  endtask : cpu_read

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    repeat (2) @(negedge clock_i);
    check("reset done", 8'(link.conv_done), 8'h01);
    check("reset start", 8'(start_active), 8'h00);
    check("reset bus", link.bus_data, 8'hFF);
    rst_b_i = 1'b1;
    $display("Test reset done");
  endtask : t_reset

  // Steady input must come back exactly from the approximation
  task automatic t_convert(input logic [7:0] lvl);
    analog_level = lvl;
    cpu_write(1'b0, 1'b1, 1'b1);
    wait_for("busy", busy, 1'b1, 40);
    check("ready early", 8'(result_ready), 8'h00);
    wait_for("ready", result_ready, 1'b1, 400);
    check("result", result, lvl);
    check("done high", 8'(done_seen), 8'h01);
    cpu_read(1'b1, 1'b0, 1'b1, lvl);
    $display("Test convert %h done", lvl);
  endtask : t_convert

  // Other bit ten/eleven pairs must neither start nor select
  task automatic t_decode();
    logic [1:0] wr [3] = '{2'b10, 2'b11, 2'b00};
    logic [1:0] rd [3] = '{2'b01, 2'b11, 2'b00};
    for (int i = 0; i < 3; i++) begin
      cpu_write(wr[i][1], wr[i][0], 1'b0);
      check("no conversion", 8'(busy), 8'h00);
      cpu_read(rd[i][1], rd[i][0], 1'b0, 8'h00);
    end
    $display("Test decode done");
  endtask : t_decode

  // Second start in mid-conversion leaves old and new results intact
  task automatic t_busy();
    analog_level = 8'h3C;
    cpu_write(1'b0, 1'b1, 1'b1);
    wait_for("busy", busy, 1'b1, 40);
    check("old result kept", result, 8'hA5);
    repeat (16) @(negedge clock_i);
    cpu_write(1'b0, 1'b1, 1'b1);
    wait_for("ready", result_ready, 1'b1, 400);
    check("result", result, 8'h3C);
    repeat (12) @(negedge clock_i);
    check("no restart", 8'(busy), 8'h00);
    $display("Test busy restart done");
  endtask : t_busy

  initial begin
    t_reset();
    foreach (levels[i]) t_convert(levels[i]);
    t_decode();
    t_busy();
    end_sim();
  end

  // Watchdog well beyond the expected run of under 1500 cycles
  initial begin
    repeat (10000) @(posedge clock_i);
    err_total++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_sim();
  end
endmodule : adc_bus_interface_tb
